// ==== transport_adaptation_timing_bench.sv ====
// Purpose: Self-checking bench for the encoder and receiver ends
// Assumes: hclk 125 MHz, AV_DIV set small
// Notes:   Second receiver takes a faulty link from the bench
`timescale 1ns/1ns
`default_nettype none
module transport_adaptation_timing_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic               hclk, hresetn, hsel, hwrite, hready, hresp, es_valid, chan_change;
  logic        [31:0] haddr, hwdata, hrdata, rd;
  logic        [1:0]  htrans;
  logic        [7:0]  es_data, b, scnt;
  logic        [12:0] sel_stream;
  logic        [41:0] stc, s, d;
  logic signed [42:0] perr;
  logic               pcr_seen, av_tick, rap, disc, szero, cc_err, sync_err, sync_err2;
  logic               discard, pay_valid;
  int                 mismatches, check_count, ccn, avn, s2n, n;
  ts_link_if l1 ();
  ts_link_if l2 ();
  initial begin
    hclk = 1'h0;
    forever #4 hclk = ~hclk;
  end
  // ----------------------------------------
  // Ends and checker
  // ----------------------------------------
  ts_adapt_tx i_ts_adapt_tx (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout_q(hready), .hrdata_q(hrdata), .hresp_q(hresp), .es_data(es_data),
    .es_valid(es_valid), .es_ready_q(), .link(l1.enc));
  ts_adapt_rx #(.AV_DIV(4)) i_ts_adapt_rx (.hclk(hclk), .hresetn(hresetn), .link(l1.dec),
    .sel_stream(sel_stream), .chan_change(chan_change), .stc_q(stc), .phase_err_q(perr),
    .pcr_seen_q(pcr_seen), .av_tick_q(av_tick), .rap_q(rap), .disc_q(disc),
    .splice_zero_q(szero), .splice_cnt_q(scnt), .cc_err_q(cc_err), .sync_err_q(sync_err),
    .discard_q(discard), .pay_data_q(), .pay_valid_q(pay_valid));
  ts_adapt_rx #(.AV_DIV(4)) i_ts_adapt_rx2 (.hclk(hclk), .hresetn(hresetn), .link(l2.dec),
    .sel_stream(sel_stream), .chan_change(chan_change), .stc_q(), .phase_err_q(),
    .pcr_seen_q(), .av_tick_q(), .rap_q(), .disc_q(), .splice_zero_q(), .splice_cnt_q(),
    .cc_err_q(), .sync_err_q(sync_err2), .discard_q(), .pay_data_q(), .pay_valid_q());
  ts_link_asserts i_ts_link_asserts (.hclk(hclk), .hresetn(hresetn), .ts_data(l1.ts_data),
    .ts_valid(l1.ts_valid), .ts_sop(l1.ts_sop));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [42:0] seen, input logic [42:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic hwait();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'h1 && k < 64);
    if (hready !== 1'h1) begin
      mismatches++;
      give_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    hwait();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    hwait();
    rd = hrdata;
  endtask
  function automatic logic ev(input int k);
    case (k)
      0: return rap;
      1: return szero;
      2: return disc;
      3: return pcr_seen;
      default: return pay_valid;
    endcase
  endfunction
  task automatic wt(input int k);
    int m;
    m = 0;
    do begin
      @(posedge hclk);
      #1;
      m++;
    end while (ev(k) !== 1'h1 && m < 3000);
    if (ev(k) !== 1'h1) begin
      mismatches++;
      give_verdict();
    end
  endtask
  // ----------------------------------------
  // Monitors and stream source
  // ----------------------------------------
  always @(posedge hclk) begin
    es_data <= es_data + 8'h01;
    if (cc_err === 1'h1 || sync_err === 1'h1) ccn++;
    if (av_tick === 1'h1) avn++;
    if (sync_err2 === 1'h1) s2n++;
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {hresetn, hsel, hwrite, chan_change, haddr, hwdata, htrans, es_data} = '0;
    {l2.ts_data, l2.ts_valid, l2.ts_sop, ccn, avn, s2n, mismatches, check_count} = '0;
    es_valid = 1'h1;
    sel_stream = 13'h0101;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    #1;
    chk(discard, 1'h1);
    @(posedge hclk);
    bus(1'h1, 32'h0, 32'h00030101);
    bus(1'h0, 32'h0, 32'h0);
    chk(rd, 32'h00030101);
    chk(hresp, 1'h0);
    bus(1'h0, 32'h10, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, 32'h4, 32'h1);
    bus(1'h0, 32'h4, 32'h0);
    chk(rd, 32'h0);
    wt(0);
    @(posedge hclk);
    #1;
    chk(discard, 1'h0);
    wt(4);
    n = 0;
    while (l1.ts_sop !== 1'h1 && n < 400) begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk(l1.ts_data, 8'h47);
    @(posedge hclk);
    #1;
    b = l1.ts_data;
    @(posedge hclk);
    #1;
    chk({b[4:0], l1.ts_data}, 13'h0101);
    @(posedge hclk);
    #1;
    chk(l1.ts_data[5:4], 2'h3);
    wt(3);
    wt(3);
    chk(perr > -43'sh10 && perr < 43'sh10, 1'h1);
    s = stc;
    avn = 0;
    repeat (1000) @(posedge hclk);
    d = stc - s;
    chk(d >= 42'hD7 && d <= 42'hD9, 1'h1);
    chk(avn >= 32'h35 && avn <= 32'h37, 1'h1);
    bus(1'h1, 32'h8, 32'h2);
    bus(1'h0, 32'hC, 32'h0);
    chk(rd[16], 1'h1);
    wt(1);
    chk(scnt, 8'h0);
    wt(2);
    chk(rap, 1'h1);
    bus(1'h1, 32'h4, 32'h2);
    wt(2);
    chan_change <= 1'h1;
    @(posedge hclk);
    chan_change <= 1'h0;
    @(posedge hclk);
    #1;
    chk(discard, 1'h1);
    l2.ts_valid <= 1'h1;
    l2.ts_sop <= 1'h1;
    l2.ts_data <= 8'h12;
    @(posedge hclk);
    l2.ts_valid <= 1'h0;
    l2.ts_sop <= 1'h0;
    l2.ts_data <= 8'hED;
    repeat (4) @(posedge hclk);
    chk(s2n, 32'h1);
    chk(ccn, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== ts_adapt_pkg.sv ====
// Purpose: Types shared by both transport ends
// Assumes: Nothing
// Notes:   State enums only
package ts_adapt_pkg;
  typedef enum logic [3:0] {
    RX_HDR, RX_SKIP, RX_AFLEN, RX_AFFLG, RX_PCR, RX_OPCR, RX_SPL, RX_AFSKIP, RX_PAY
  } rx_state_t;
  typedef enum logic [2:0] {
    TX_IDLE, TX_HDR, TX_AFLEN, TX_AFFLG, TX_PCR, TX_SPL, TX_PAY
  } tx_state_t;
endpackage

// ==== ts_adapt_regs.svh ====
// Purpose: Shared constants for the transport adaptation timing ends
// Assumes: 125 MHz hclk, 27 MHz system time, byte-wide packet link
// Notes:   Definitions only
`ifndef TS_ADAPT_REGS_SVH
`define TS_ADAPT_REGS_SVH
// ----------------------------------------
// Framing
// ----------------------------------------
`define TS_SYNC       8'h47
`define TS_PKT_LEN    8'd188
`define FLG_DISC      7
`define FLG_RAP       6
`define FLG_PCR       4
`define FLG_OPCR      3
`define FLG_SPL       2
// ----------------------------------------
// System time
// ----------------------------------------
`define STC_HZ        64'd27000000
`define HCLK_HZ       64'd125000000
`define STC_STEP      (32'((`STC_HZ << 32) / `HCLK_HZ))
`define STC_ADJ       32'h00000100
`define PCR_EXT_MOD   42'd300
`define PCR_EXT_MAX   9'd299
// ----------------------------------------
// Controller registers
// ----------------------------------------
`define REG_CTRL      12'h000
`define REG_CMD       12'h004
`define REG_SPLICE    12'h008
`define REG_STATUS    12'h00C
`define CTRL_EN       16
`define CTRL_PCR      17
`define CMD_RAP       0
`define CMD_DISC      1
`define CTRL_RST      32'h00000000
`endif

// ==== ts_adapt_rx.sv ====
// Purpose: Receiver end: adaptation header parse, system time recovery
// Assumes: Link bytes synchronous to hclk, ts_sop on the sync byte
// Notes:   One selected stream
`timescale 1ns/1ns
`default_nettype none
`include "ts_adapt_regs.svh"
module ts_adapt_rx
  import ts_adapt_pkg::*;
#(
  parameter int unsigned AV_DIV = 562
) (
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // Transport link
  ts_link_if.dec                  link,
  // Control
  input  wire logic [12:0]        sel_stream,
  input  wire logic               chan_change,
  // System time
  output logic        [41:0]      stc_q,
  output logic signed [42:0]      phase_err_q,
  output logic                    pcr_seen_q,
  output logic                    av_tick_q,
  // Events
  output logic                    rap_q,
  output logic                    disc_q,
  output logic                    splice_zero_q,
  output logic        [7:0]       splice_cnt_q,
  output logic                    cc_err_q,
  output logic                    sync_err_q,
  output logic                    discard_q,
  // Payload
  output logic        [7:0]       pay_data_q,
  output logic                    pay_valid_q
);

  rx_state_t   state_q;
  rx_state_t   af_nx;
  rx_state_t   body_st;
  logic [2:0]  fcnt_q;
  logic [4:0]  pid_hi_q;
  logic        match_q;
  logic [1:0]  afc_q;
  logic [7:0]  af_left_q;
  logic [7:0]  flags_q;
  logic [7:0]  fl;
  logic [39:0] pcr_sr_q;
  logic [3:0]  cc_q;
  logic        cc_ok_q;
  logic        load_q;
  logic [31:0] step_q;
  logic [31:0] acc_q;
  logic [32:0] acc_sum;
  logic [15:0] av_cnt_q;
  logic [47:0] pcr_raw;
  logic [41:0] pcr_lin;
  logic signed [42:0] err_now;
  logic [7:0]  d;
  logic        flg_now;
  logic        pcr_now;
  logic        spl_now;
  logic        hdr3;

  // ----------------------------------------
  // Byte strobes
  // ----------------------------------------
  assign d       = link.ts_data;
  assign body_st = afc_q[0] ? RX_PAY : RX_SKIP;
  assign flg_now = link.ts_valid && !link.ts_sop && state_q == RX_AFFLG && match_q;
  assign pcr_now = link.ts_valid && !link.ts_sop && state_q == RX_PCR && fcnt_q == 3'd5
                   && match_q;
  assign spl_now = link.ts_valid && !link.ts_sop && state_q == RX_SPL && match_q;
  assign hdr3    = link.ts_valid && !link.ts_sop && state_q == RX_HDR && fcnt_q == 3'd3;
  assign pcr_raw = {pcr_sr_q, d};
  assign pcr_lin = 42'(pcr_raw[47:15]) * `PCR_EXT_MOD + 42'(pcr_raw[8:0]);
  assign err_now = $signed({1'b0, pcr_lin}) - $signed({1'b0, stc_q});
  assign acc_sum = {1'b0, acc_q} + {1'b0, step_q};

  // ----------------------------------------
  // Adaptation field walk
  // ----------------------------------------
  always_comb begin
    fl    = (state_q == RX_AFFLG) ? d : flags_q;
    af_nx = RX_AFSKIP;
    case (state_q)
      RX_AFFLG: begin
        if (fl[`FLG_PCR])       af_nx = RX_PCR;
        else if (fl[`FLG_OPCR]) af_nx = RX_OPCR;
        else if (fl[`FLG_SPL])  af_nx = RX_SPL;
      end
      RX_PCR: begin
        if (fcnt_q != 3'd5)     af_nx = RX_PCR;
        else if (fl[`FLG_OPCR]) af_nx = RX_OPCR;
        else if (fl[`FLG_SPL])  af_nx = RX_SPL;
      end
      RX_OPCR: begin
        if (fcnt_q != 3'd5)     af_nx = RX_OPCR;
        else if (fl[`FLG_SPL])  af_nx = RX_SPL;
      end
      default: af_nx = RX_AFSKIP;
    endcase
  end

  // ----------------------------------------
  // Packet parser
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= RX_SKIP;
      fcnt_q    <= 3'd0;
      pid_hi_q  <= 5'h00;
      match_q   <= 1'b0;
      afc_q     <= 2'b00;
      af_left_q <= 8'h00;
      flags_q   <= 8'h00;
      pcr_sr_q  <= 40'h0;
    end else if (link.ts_valid) begin
      if (link.ts_sop) begin
        fcnt_q  <= 3'd1;
        match_q <= 1'b0;
        state_q <= (d == `TS_SYNC) ? RX_HDR : RX_SKIP;
      end else begin
        case (state_q)
          RX_HDR: begin
            fcnt_q <= fcnt_q + 3'd1;
            if (fcnt_q == 3'd1) pid_hi_q <= d[4:0];
            if (fcnt_q == 3'd2) match_q <= ({pid_hi_q, d} == sel_stream);
            if (fcnt_q == 3'd3) begin
              afc_q <= d[5:4];
              if (d[5])      state_q <= RX_AFLEN;
              else if (d[4]) state_q <= RX_PAY;
              else           state_q <= RX_SKIP;
            end
          end
          RX_AFLEN: begin
            af_left_q <= d;
            state_q   <= (d == 8'h00) ? body_st : RX_AFFLG;
          end
          RX_AFFLG, RX_PCR, RX_OPCR, RX_SPL, RX_AFSKIP: begin
            af_left_q <= af_left_q - 8'd1;
            fcnt_q    <= (state_q == RX_AFFLG || fcnt_q == 3'd5) ? 3'd0 : fcnt_q + 3'd1;
            if (state_q == RX_AFFLG) flags_q <= d;
            if (state_q == RX_PCR)   pcr_sr_q <= {pcr_sr_q[31:0], d};
            state_q <= (af_left_q == 8'd1) ? body_st : af_nx;
          end
          default: state_q <= state_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Events
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rap_q         <= 1'b0;
      disc_q        <= 1'b0;
      splice_zero_q <= 1'b0;
      splice_cnt_q  <= 8'h00;
      sync_err_q    <= 1'b0;
    end else begin
      rap_q         <= flg_now && d[`FLG_RAP];
      disc_q        <= flg_now && d[`FLG_DISC];
      splice_zero_q <= spl_now && d == 8'h00;
      sync_err_q    <= link.ts_valid && link.ts_sop && d != `TS_SYNC;
      if (spl_now) splice_cnt_q <= d;
    end
  end

  // ----------------------------------------
  // Sequence count check
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cc_q     <= 4'h0;
      cc_ok_q  <= 1'b0;
      cc_err_q <= 1'b0;
    end else begin
      cc_err_q <= 1'b0;
      if (chan_change) begin
        cc_ok_q <= 1'b0;
      end else if (hdr3 && match_q && d[4]) begin
        cc_q    <= d[3:0];
        cc_ok_q <= 1'b1;
        cc_err_q <= cc_ok_q && d[3:0] != cc_q + 4'd1 && d[3:0] != cc_q;
      end
    end
  end

  // ----------------------------------------
  // Resync discard and phase load
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      discard_q <= 1'b1;
      load_q    <= 1'b1;
    end else begin
      if (chan_change)                        discard_q <= 1'b1;
      else if (flg_now && d[`FLG_RAP])        discard_q <= 1'b0;
      if (chan_change || (flg_now && d[`FLG_DISC])) load_q <= 1'b1;
      else if (pcr_now)                       load_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Payload out
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pay_data_q  <= 8'h00;
      pay_valid_q <= 1'b0;
    end else begin
      pay_data_q  <= d;
      pay_valid_q <= link.ts_valid && !link.ts_sop && state_q == RX_PAY
                     && match_q && !discard_q;
    end
  end

  // ----------------------------------------
  // Local system time
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q  <= 32'h0;
      step_q <= `STC_STEP;
      stc_q  <= 42'h0;
    end else begin
      acc_q <= acc_sum[31:0];
      if (pcr_now && load_q) begin
        stc_q <= pcr_lin;
      end else begin
        stc_q <= stc_q + 42'(acc_sum[32]);
      end
      if (pcr_now && !load_q) begin
        if (err_now > 0)      step_q <= step_q + `STC_ADJ;
        else if (err_now < 0) step_q <= step_q - `STC_ADJ;
      end
    end
  end

  // Time error report
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_err_q <= 43'sd0;
      pcr_seen_q  <= 1'b0;
    end else begin
      pcr_seen_q <= pcr_now;
      if (pcr_now) phase_err_q <= err_now;
    end
  end

  // Sample clock derived from recovered time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      av_cnt_q  <= 16'h0;
      av_tick_q <= 1'b0;
    end else begin
      av_tick_q <= 1'b0;
      if (acc_sum[32]) begin
        if (av_cnt_q == 16'(AV_DIV - 1)) begin
          av_cnt_q  <= 16'h0;
          av_tick_q <= 1'b1;
        end else begin
          av_cnt_q <= av_cnt_q + 16'd1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== ts_adapt_tx.sv ====
// Purpose: Encoder end: builds packets with adaptation headers
// Assumes: AHB-Lite slave for control, one byte per cycle out
// Notes:   Zero wait state bus
`timescale 1ns/1ns
`default_nettype none
`include "ts_adapt_regs.svh"
module ts_adapt_tx
  import ts_adapt_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout_q,
  output logic [31:0]      hrdata_q,
  output logic             hresp_q,
  // Elementary stream in
  input  wire logic [7:0]  es_data,
  input  wire logic        es_valid,
  output logic             es_ready_q,
  // Transport link
  ts_link_if.enc           link
);

  tx_state_t   state_q;
  tx_state_t   tx_nx;
  logic [7:0]  pos_q;
  logic [31:0] ctrl_q;
  logic [11:0] addr_q;
  logic        wr_q;
  logic        rap_pend_q;
  logic        disc_pend_q;
  logic        spl_arm_q;
  logic [7:0]  spl_cnt_q;
  logic        after_q;
  logic        pk_pcr_q, pk_rap_q, pk_disc_q, pk_spl_q, pk_af_q;
  logic [3:0]  cc_q;
  logic [15:0] pkt_cnt_q;
  logic [47:0] pcr_sr_q;
  logic [32:0] base_q;
  logic [8:0]  ext_q;
  logic [31:0] acc_q;
  logic [32:0] acc_sum;
  logic [7:0]  af_len;
  logic [7:0]  af_flags;
  logic [7:0]  data_q;
  logic        valid_q;
  logic        sop_q;
  logic        take;
  logic        pk_start;

  assign take     = hsel && htrans[1] && hready;
  assign pk_start = state_q == TX_HDR && pos_q == 8'd0;
  assign acc_sum  = {1'b0, acc_q} + {1'b0, `STC_STEP};
  assign af_len   = 8'd1 + (pk_pcr_q ? 8'd6 : 8'd0) + (pk_spl_q ? 8'd1 : 8'd0);
  assign link.ts_data  = data_q;
  assign link.ts_valid = valid_q;
  assign link.ts_sop   = sop_q;

  always_comb begin
    af_flags = 8'h00;
    af_flags[`FLG_DISC] = pk_disc_q;
    af_flags[`FLG_RAP]  = pk_rap_q;
    af_flags[`FLG_PCR]  = pk_pcr_q;
    af_flags[`FLG_SPL]  = pk_spl_q;
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q        <= 1'b0;
      addr_q      <= 12'h000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      hrdata_q    <= 32'h0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      wr_q        <= take && hwrite && hsize == 3'b010 && haddr[31:12] == 20'h0;
      if (take) addr_q <= haddr[11:0];
      if (take && !hwrite) begin
        case (haddr)
          32'(`REG_CTRL):   hrdata_q <= ctrl_q;
          32'(`REG_SPLICE): hrdata_q <= {24'h0, spl_cnt_q};
          32'(`REG_STATUS): hrdata_q <= {15'h0, spl_arm_q, pkt_cnt_q};
          default:          hrdata_q <= 32'h0;
        endcase
      end
    end
  end

  // Control and one-shot requests
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q      <= `CTRL_RST;
      rap_pend_q  <= 1'b0;
      disc_pend_q <= 1'b0;
    end else begin
      if (wr_q && addr_q == `REG_CTRL) ctrl_q <= hwdata;
      if (wr_q && addr_q == `REG_CMD && hwdata[`CMD_RAP]) rap_pend_q <= 1'b1;
      else if (pk_start) rap_pend_q <= 1'b0;
      if (wr_q && addr_q == `REG_CMD && hwdata[`CMD_DISC]) disc_pend_q <= 1'b1;
      else if (pk_start) disc_pend_q <= 1'b0;
    end
  end

  // Splice countdown toward a packet boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spl_arm_q <= 1'b0;
      spl_cnt_q <= 8'h00;
      after_q   <= 1'b0;
    end else begin
      if (wr_q && addr_q == `REG_SPLICE) begin
        spl_arm_q <= 1'b1;
        spl_cnt_q <= hwdata[7:0];
      end else if (state_q == TX_SPL) begin
        if (spl_cnt_q == 8'h00) spl_arm_q <= 1'b0;
        else spl_cnt_q <= spl_cnt_q - 8'd1;
      end
      if (state_q == TX_SPL && spl_cnt_q == 8'h00) after_q <= 1'b1;
      else if (pk_start) after_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // System time, free running
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q  <= 32'h0;
      ext_q  <= 9'h000;
      base_q <= 33'h0;
    end else begin
      acc_q <= acc_sum[31:0];
      if (acc_sum[32]) begin
        if (ext_q == `PCR_EXT_MAX) begin
          ext_q  <= 9'h000;
          base_q <= base_q + 33'd1;
        end else begin
          ext_q <= ext_q + 9'd1;
        end
      end
    end
  end

  // ----------------------------------------
  // Packet sequencer
  // ----------------------------------------
  always_comb begin
    tx_nx = state_q;
    case (state_q)
      TX_IDLE:  if (ctrl_q[`CTRL_EN]) tx_nx = TX_HDR;
      TX_HDR:   if (pos_q == 8'd3) tx_nx = pk_af_q ? TX_AFLEN : TX_PAY;
      TX_AFLEN: tx_nx = TX_AFFLG;
      TX_AFFLG: tx_nx = pk_pcr_q ? TX_PCR : (pk_spl_q ? TX_SPL : TX_PAY);
      TX_PCR:   if (pos_q == 8'd11) tx_nx = pk_spl_q ? TX_SPL : TX_PAY;
      TX_SPL:   tx_nx = TX_PAY;
      TX_PAY:   if (pos_q == `TS_PKT_LEN - 8'd1) tx_nx = ctrl_q[`CTRL_EN] ? TX_HDR : TX_IDLE;
      default:  tx_nx = TX_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= TX_IDLE;
      pos_q      <= 8'd0;
      es_ready_q <= 1'b0;
      pk_pcr_q   <= 1'b0;
      pk_rap_q   <= 1'b0;
      pk_disc_q  <= 1'b0;
      pk_spl_q   <= 1'b0;
      pk_af_q    <= 1'b0;
      cc_q       <= 4'h0;
      pkt_cnt_q  <= 16'h0;
    end else begin
      state_q    <= tx_nx;
      es_ready_q <= tx_nx == TX_PAY;
      pos_q      <= (tx_nx == TX_HDR && state_q != TX_HDR) ? 8'd0 : pos_q + 8'd1;
      if (pk_start) begin
        pk_pcr_q  <= ctrl_q[`CTRL_PCR];
        pk_rap_q  <= rap_pend_q || after_q;
        pk_disc_q <= disc_pend_q || after_q;
        pk_spl_q  <= spl_arm_q;
        pk_af_q   <= ctrl_q[`CTRL_PCR] || rap_pend_q || disc_pend_q || after_q || spl_arm_q;
        pkt_cnt_q <= pkt_cnt_q + 16'd1;
      end
      if (state_q == TX_HDR && pos_q == 8'd3) cc_q <= cc_q + 4'd1;
    end
  end

  // Byte output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_q   <= 8'h00;
      valid_q  <= 1'b0;
      sop_q    <= 1'b0;
      pcr_sr_q <= 48'h0;
    end else begin
      valid_q <= state_q != TX_IDLE;
      sop_q   <= pk_start;
      if (state_q == TX_AFFLG) pcr_sr_q <= {base_q, 6'h3F, ext_q};
      else if (state_q == TX_PCR) pcr_sr_q <= {pcr_sr_q[39:0], 8'h00};
      case (state_q)
        TX_HDR: begin
          case (pos_q[1:0])
            2'd0:    data_q <= `TS_SYNC;
            2'd1:    data_q <= {3'h0, ctrl_q[12:8]};
            2'd2:    data_q <= ctrl_q[7:0];
            default: data_q <= {2'b00, pk_af_q, 1'b1, cc_q};
          endcase
        end
        TX_AFLEN: data_q <= af_len;
        TX_AFFLG: data_q <= af_flags;
        TX_PCR:   data_q <= pcr_sr_q[47:40];
        TX_SPL:   data_q <= spl_cnt_q;
        TX_PAY:   data_q <= es_valid ? es_data : 8'hFF;
        default:  data_q <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== ts_link_asserts.sv ====
// Purpose: Link-level checks between encoder and receiver ends
// Assumes: One byte per cycle while ts_valid, hclk domain
// Notes:   Instantiated beside the link interface
`timescale 1ns/1ns
`default_nettype none
module ts_link_asserts (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Link
  input wire logic [7:0] ts_data,
  input wire logic       ts_valid,
  input wire logic       ts_sop
);
  // ----------------------------------------
  // Byte position tracking
  // ----------------------------------------
  logic [7:0] idx_q, cur, cpos, fl_q;
  logic [3:0] cc_q;
  logic       on_q, cc_on_q, afp_q, zero_q;
  assign cur  = ts_sop ? 8'h00 : idx_q + 8'h01;
  assign cpos = fl_q[4] ? 8'h0C : 8'h06;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_q   <= 8'h00;
      fl_q    <= 8'h00;
      cc_q    <= 4'h0;
      on_q    <= 1'h0;
      cc_on_q <= 1'h0;
      afp_q   <= 1'h0;
      zero_q  <= 1'h0;
    end else if (ts_valid) begin
      idx_q <= cur;
      on_q  <= on_q | ts_sop;
      if (cur == 8'h03) begin
        cc_q    <= ts_data[3:0];
        cc_on_q <= 1'h1;
        afp_q   <= ts_data[5];
      end
      if (cur == 8'h05) begin
        fl_q   <= ts_data;
        zero_q <= 1'h0;
      end
      if (afp_q && fl_q[2] && cur == cpos && cur > 8'h05)
        zero_q <= (ts_data == 8'h00);
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_SOP_SYNC: assert property (ts_sop |-> ts_valid && ts_data == 8'h47)
    else $error("start byte is not the sync value");
  AST_PKT_LEN: assert property (on_q && ts_valid && idx_q == 8'hBB |-> ts_sop)
    else $error("packet longer than its fixed length");
  AST_PKT_EDGE: assert property (on_q && ts_sop |-> idx_q == 8'hBB)
    else $error("packet start inside a packet");
  AST_HDR_BITS: assert property (ts_valid && cur == 8'h03 |-> ts_data[7:6] == 2'h0 && ts_data[4])
    else $error("header byte three malformed");
  AST_CC_STEP: assert property (ts_valid && cur == 8'h03 && cc_on_q |-> ts_data[3:0] == cc_q + 4'h1)
    else $error("sequence count did not step by one");
  AST_AF_LEN: assert property (ts_valid && cur == 8'h04 && afp_q |-> ts_data <= 8'hB7)
    else $error("adaptation length beyond packet");
  AST_EXT_RANGE: assert property (ts_valid && cur == 8'h0B && afp_q && fl_q[4] |-> {$past(ts_data[0]), ts_data} <= 9'h12B)
    else $error("sample extension out of range");
  AST_DISC_NEXT: assert property (ts_valid && cur == 8'h05 && zero_q |-> afp_q && ts_data[7:6] == 2'h3)
    else $error("no discontinuity after countdown zero");
endmodule
`default_nettype wire

// ==== ts_link_if.sv ====
// Purpose: Byte-wide transport packet link between encoder and receiver
// Assumes: Both ends on hclk
// Notes:   One byte per cycle while ts_valid
`timescale 1ns/1ns
`default_nettype none
interface ts_link_if;
  logic [7:0] ts_data;
  logic       ts_valid;
  logic       ts_sop;
  modport enc (output ts_data, output ts_valid, output ts_sop);
  modport dec (input ts_data, input ts_valid, input ts_sop);
endinterface
`default_nettype wire
